// ---- csp_bank_model.sv ----
// Purpose: behavioural capacitor switch with position contact
// Assumes: relay pulses on the supervisor clock
// Notes: fail_i holds the switch open, so no close takes effect
`default_nettype none
module csp_bank_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// relay coils and fault control
	input wire logic trip_i,
	input wire logic close_i,
	input wire logic fail_i,
	// position contact
	output logic bank_closed_o
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || trip_i || fail_i) begin
			bank_closed_o <= 1'b0;
		end else if (close_i) begin
			bank_closed_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- csp_pkg.sv ----
// Purpose: shared constants for the capacitor switch protection block
// Assumes: 20 MHz system clock, 16-bit register data, word-index addressing
// Notes: times are kept in their own unit; only the one-second tick is turned into clock counts here
`default_nettype none
package csp_pkg;
	// ****************************************
	// clock and timebase
	// ****************************************
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned TICK_S = 1;
	localparam int unsigned SEC_CYC_DEF = CLK_HZ * TICK_S;
	localparam int unsigned SEC_W = 25;
	localparam logic [5:0] SEC_PER_MIN = 6'h3c;
	localparam logic [2:0] DAYS_PER_WEEK = 3'h7;
	localparam logic [4:0] PU_TRIP_LIMIT_S = 5'h1e;
	localparam logic [7:0] NC_VERIFY_S = 8'h0a;

	// ****************************************
	// register bus
	// ****************************************
	localparam int unsigned AW = 4;
	localparam int unsigned DW = 16;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_AH_MIN = 4'h1;
	localparam logic [3:0] OFS_AH_DLY = 4'h2;
	localparam logic [3:0] OFS_UV_LIM = 4'h3;
	localparam logic [3:0] OFS_DAY_MAX = 4'h4;
	localparam logic [3:0] OFS_NC_LIM = 4'h5;
	localparam logic [3:0] OFS_NC_DLY = 4'h6;
	localparam logic [3:0] OFS_NC_RCL = 4'h7;
	localparam logic [3:0] OFS_AUX_LIM = 4'h8;
	localparam logic [3:0] OFS_AUX_DLY = 4'h9;
	localparam logic [3:0] OFS_PU_DLY = 4'ha;
	localparam logic [3:0] OFS_STATUS = 4'hb;
	localparam logic [3:0] OFS_IRQ_STAT = 4'hc;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hd;
	localparam logic [3:0] OFS_CLOSE_CNT = 4'he;
	localparam logic [3:0] OFS_AH_ACC = 4'hf;

	// ****************************************
	// control bits
	// ****************************************
	localparam int unsigned CB_AH = 0;
	localparam int unsigned CB_UV = 1;
	localparam int unsigned CB_DL = 2;
	localparam int unsigned CB_NC = 3;
	localparam int unsigned CB_PU = 4;
	localparam int unsigned CB_AUX = 5;
	localparam logic [15:0] CTRL_RST = 16'h0010;

	// ****************************************
	// events and status bits
	// ****************************************
	localparam int unsigned NEV = 6;
	localparam int unsigned EV_HUNT = 0;
	localparam int unsigned EV_NC_TRIP = 1;
	localparam int unsigned EV_LOCK = 2;
	localparam int unsigned EV_PU_TRIP = 3;
	localparam int unsigned EV_AUX_TRIP = 4;
	localparam int unsigned EV_REFUSED = 5;

	// ****************************************
	// neutral current sequence
	// ****************************************
	typedef enum logic [2:0] {
		CSP_NC_IDLE = 3'b000,
		CSP_NC_DELAY = 3'b001,
		CSP_NC_RECL = 3'b010,
		CSP_NC_VERIFY = 3'b011,
		CSP_NC_LOCK = 3'b100
	} csp_nc_t;
endpackage
`default_nettype wire

// ---- csp_protect.sv ----
// Purpose: supervisor deciding which trip and close commands reach the relays
// Assumes: requests and measurements come from logic on clk_i; switch and
//   bank position come from pins; power restoration is the release of reset
// Notes: relay outputs are one-cycle pulses
//
// Functional notes
// - with anti-hunt on, time close-to-trip; shorter than minimum means hunting.
// - each hunting event adds the close-inhibit delay to the accumulated delay.
// - refuse every close while the accumulated delay runs after a trip.
// - clear the accumulated anti-hunt delay every seven days.
// - with undervoltage inhibit on, block all relays at or below the limit.
// - with daily limit on, block closes once the day's count hits maximum.
// - clear the daily close count at every midnight.
// - neutral current over limit starts the delay; trip when it expires.
// - after the neutral trip wait the reclose period, then close.
// - bank not staying closed after that reclose enters lockout.
// - drive the lockout lamp for the whole lockout.
// - only the external reset switch leaves lockout; here system reset also returns the sequence to idle.
// - with power-up trip on, trip within 30 seconds of power return.
// - after power-up trip, closes wait the setpoint delay.
// - voltage over auxiliary setpoint trips within the auxiliary delay.
// - auxiliary trip and voltage override work together, neither disables other.
`default_nettype none
module csp_protect #(
	parameter int unsigned SEC_CYCLES = csp_pkg::SEC_CYC_DEF
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [csp_pkg::AW-1:0] reg_addr_i,
	input wire logic [csp_pkg::DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [csp_pkg::DW-1:0] reg_rdata_o,
	// primary control and time of day
	input wire logic pri_close_i,
	input wire logic pri_trip_i,
	input wire logic midnight_i,
	// measurements
	input wire logic [csp_pkg::DW-1:0] line_volt_i,
	input wire logic [csp_pkg::DW-1:0] neut_curr_i,
	// pins
	input wire logic bank_closed_i,
	input wire logic reset_sw_i,
	// outputs
	output logic trip_o,
	output logic close_o,
	output logic lock_lamp_o,
	output logic irq_o
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] pin_m_reg;
	logic [1:0] pin_s_reg;
	logic rst_sw_d_reg;
	logic bank_closed_s;
	logic rst_sw_s;
	logic rst_sw_rise;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_m_reg <= 2'h0;
			pin_s_reg <= 2'h0;
			rst_sw_d_reg <= 1'b0;
		end else begin
			pin_m_reg <= {reset_sw_i, bank_closed_i};
			pin_s_reg <= pin_m_reg;
			rst_sw_d_reg <= pin_s_reg[1];
		end
	end

	assign bank_closed_s = pin_s_reg[0];
	assign rst_sw_s = pin_s_reg[1];
	assign rst_sw_rise = rst_sw_s & ~rst_sw_d_reg;

	// ****************************************
	// timebase
	// ****************************************
	localparam logic [csp_pkg::SEC_W-1:0] SEC_LAST = csp_pkg::SEC_W'(SEC_CYCLES - 1);
	logic [csp_pkg::SEC_W-1:0] sec_cnt_reg;
	logic [5:0] min_sec_reg;
	logic [2:0] day_cnt_reg;
	logic sec_tick;
	logic min_tick;
	logic week_tick;

	assign sec_tick = (sec_cnt_reg == SEC_LAST);
	assign min_tick = sec_tick & (min_sec_reg == csp_pkg::SEC_PER_MIN - 6'h1);
	assign week_tick = midnight_i & (day_cnt_reg == csp_pkg::DAYS_PER_WEEK - 3'h1);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sec_cnt_reg <= '0;
			min_sec_reg <= 6'h0;
			day_cnt_reg <= 3'h0;
		end else begin
			sec_cnt_reg <= sec_tick ? '0 : sec_cnt_reg + 1'b1;
			if (sec_tick) begin
				min_sec_reg <= min_tick ? 6'h0 : min_sec_reg + 6'h1;
			end
			if (midnight_i) begin
				day_cnt_reg <= week_tick ? 3'h0 : day_cnt_reg + 3'h1;
			end
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	logic [csp_pkg::DW-1:0] ctrl_reg;
	logic [csp_pkg::DW-1:0] ah_min_reg;
	logic [csp_pkg::DW-1:0] ah_dly_reg;
	logic [csp_pkg::DW-1:0] uv_lim_reg;
	logic [csp_pkg::DW-1:0] day_max_reg;
	logic [csp_pkg::DW-1:0] nc_lim_reg;
	logic [csp_pkg::DW-1:0] nc_dly_reg;
	logic [csp_pkg::DW-1:0] nc_rcl_reg;
	logic [csp_pkg::DW-1:0] aux_lim_reg;
	logic [csp_pkg::DW-1:0] aux_dly_reg;
	logic [csp_pkg::DW-1:0] pu_dly_reg;
	logic [csp_pkg::NEV-1:0] irq_mask_reg;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl_reg <= csp_pkg::CTRL_RST;
			ah_min_reg <= '0;
			ah_dly_reg <= '0;
			uv_lim_reg <= '0;
			day_max_reg <= '0;
			nc_lim_reg <= '1;
			nc_dly_reg <= '0;
			nc_rcl_reg <= '0;
			aux_lim_reg <= '1;
			aux_dly_reg <= '0;
			pu_dly_reg <= '0;
			irq_mask_reg <= '0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				csp_pkg::OFS_CTRL: ctrl_reg <= reg_wdata_i;
				csp_pkg::OFS_AH_MIN: ah_min_reg <= reg_wdata_i;
				csp_pkg::OFS_AH_DLY: ah_dly_reg <= reg_wdata_i;
				csp_pkg::OFS_UV_LIM: uv_lim_reg <= reg_wdata_i;
				csp_pkg::OFS_DAY_MAX: day_max_reg <= reg_wdata_i;
				csp_pkg::OFS_NC_LIM: nc_lim_reg <= reg_wdata_i;
				csp_pkg::OFS_NC_DLY: nc_dly_reg <= reg_wdata_i;
				csp_pkg::OFS_NC_RCL: nc_rcl_reg <= reg_wdata_i;
				csp_pkg::OFS_AUX_LIM: aux_lim_reg <= reg_wdata_i;
				csp_pkg::OFS_AUX_DLY: aux_dly_reg <= reg_wdata_i;
				csp_pkg::OFS_PU_DLY: pu_dly_reg <= reg_wdata_i;
				csp_pkg::OFS_IRQ_MASK: irq_mask_reg <= reg_wdata_i[csp_pkg::NEV-1:0];
				default: ;
			endcase
		end
	end

	logic ah_en;
	logic uv_en;
	logic dl_en;
	logic nc_en;
	logic pu_en;
	logic aux_en;
	assign ah_en = ctrl_reg[csp_pkg::CB_AH];
	assign uv_en = ctrl_reg[csp_pkg::CB_UV];
	assign dl_en = ctrl_reg[csp_pkg::CB_DL];
	assign nc_en = ctrl_reg[csp_pkg::CB_NC];
	assign pu_en = ctrl_reg[csp_pkg::CB_PU];
	assign aux_en = ctrl_reg[csp_pkg::CB_AUX];

	// ****************************************
	// command arbitration
	// ****************************************
	csp_pkg::csp_nc_t nc_st_reg;
	logic nc_trip_req;
	logic nc_close_req;
	logic aux_trip_req;
	logic pu_trip_req;
	logic trip_req;
	logic close_req;
	logic lock_blk;
	logic uv_blk;
	logic ah_blk;
	logic dl_blk;
	logic pu_blk;
	logic trip_go;
	logic close_go;
	logic close_refused;

	assign lock_blk = (nc_st_reg == csp_pkg::CSP_NC_LOCK);
	assign uv_blk = uv_en & (line_volt_i <= uv_lim_reg);
	assign trip_req = pri_trip_i | nc_trip_req | aux_trip_req | pu_trip_req;
	assign close_req = pri_close_i | nc_close_req;
	assign trip_go = trip_req & ~uv_blk & ~lock_blk;
	// trip wins when both arrive together
	assign close_go = close_req & ~trip_req & ~uv_blk & ~lock_blk
		& ~ah_blk & ~dl_blk & ~pu_blk;
	assign close_refused = close_req & ~close_go;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			trip_o <= 1'b0;
			close_o <= 1'b0;
		end else begin
			trip_o <= trip_go;
			close_o <= close_go;
		end
	end

	// ****************************************
	// anti-hunt
	// ****************************************
	logic [csp_pkg::DW-1:0] since_close_reg;
	logic since_valid_reg;
	logic [csp_pkg::DW-1:0] ah_acc_reg;
	logic [csp_pkg::DW-1:0] ah_tmr_reg;
	logic hunt_ev;
	logic [csp_pkg::DW:0] ah_sum;
	logic [csp_pkg::DW-1:0] ah_acc_next;

	assign hunt_ev = ah_en & trip_go & since_valid_reg
		& (since_close_reg < ah_min_reg);
	assign ah_sum = {1'b0, ah_acc_reg} + {1'b0, ah_dly_reg};
	assign ah_acc_next = ah_sum[csp_pkg::DW] ? '1 : ah_sum[csp_pkg::DW-1:0];
	assign ah_blk = (ah_tmr_reg != '0);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			since_close_reg <= '0;
			since_valid_reg <= 1'b0;
		end else if (close_go) begin
			since_close_reg <= '0;
			since_valid_reg <= 1'b1;
		end else if (trip_go) begin
			since_valid_reg <= 1'b0;
		end else if (min_tick && since_close_reg != '1) begin
			since_close_reg <= since_close_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ah_acc_reg <= '0;
			ah_tmr_reg <= '0;
		end else if (week_tick) begin
			ah_acc_reg <= '0;
			ah_tmr_reg <= '0;
		end else if (trip_go && ah_en) begin
			ah_acc_reg <= hunt_ev ? ah_acc_next : ah_acc_reg;
			ah_tmr_reg <= hunt_ev ? ah_acc_next : ah_acc_reg;
		end else if (min_tick && ah_blk) begin
			ah_tmr_reg <= ah_tmr_reg - 1'b1;
		end
	end

	// ****************************************
	// daily close limit
	// ****************************************
	logic [csp_pkg::DW-1:0] close_cnt_reg;
	assign dl_blk = dl_en & (close_cnt_reg >= day_max_reg);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			close_cnt_reg <= '0;
		end else if (midnight_i) begin
			close_cnt_reg <= close_go ? 16'h0001 : 16'h0000;
		end else if (close_go && close_cnt_reg != '1) begin
			close_cnt_reg <= close_cnt_reg + 1'b1;
		end
	end

	// ****************************************
	// neutral current trip, reclose, lockout
	// ****************************************
	logic [csp_pkg::DW-1:0] nc_tmr_reg;
	logic nc_over;
	logic nc_tmr_done;
	logic nc_trip_ev;
	logic nc_lock_ev;
	logic nc_clr_tmr;

	assign nc_over = nc_en & (neut_curr_i > nc_lim_reg);
	assign nc_tmr_done = sec_tick & (nc_tmr_reg == '0);
	assign nc_trip_req = (nc_st_reg == csp_pkg::CSP_NC_DELAY) & nc_tmr_done;
	assign nc_close_req = (nc_st_reg == csp_pkg::CSP_NC_RECL) & nc_tmr_done;
	assign nc_trip_ev = nc_trip_req & trip_go;
	// judged from the second tick on, once the contact and its sync have settled
	assign nc_lock_ev = (nc_st_reg == csp_pkg::CSP_NC_VERIFY) & sec_tick & ~bank_closed_s
		& (nc_tmr_reg != {8'h00, csp_pkg::NC_VERIFY_S});

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			nc_st_reg <= csp_pkg::CSP_NC_IDLE;
		end else begin
			case (nc_st_reg)
				csp_pkg::CSP_NC_IDLE: begin
					if (nc_over) begin
						nc_st_reg <= csp_pkg::CSP_NC_DELAY;
					end
				end
				csp_pkg::CSP_NC_DELAY: begin
					if (!nc_over) begin
						nc_st_reg <= csp_pkg::CSP_NC_IDLE;
					end else if (nc_trip_ev) begin
						nc_st_reg <= csp_pkg::CSP_NC_RECL;
					end
				end
				csp_pkg::CSP_NC_RECL: begin
					if (nc_close_req && close_go) begin
						nc_st_reg <= csp_pkg::CSP_NC_VERIFY;
					end
				end
				csp_pkg::CSP_NC_VERIFY: begin
					if (nc_lock_ev) begin
						nc_st_reg <= csp_pkg::CSP_NC_LOCK;
					end else if (nc_tmr_done) begin
						nc_st_reg <= csp_pkg::CSP_NC_IDLE;
					end
				end
				csp_pkg::CSP_NC_LOCK: begin
					if (rst_sw_rise) begin
						nc_st_reg <= csp_pkg::CSP_NC_IDLE;
					end
				end
				default: nc_st_reg <= csp_pkg::CSP_NC_IDLE;
			endcase
		end
	end

	// timer reloads on entry to the delay, reclose and verify states, not on entry to lockout
	assign nc_clr_tmr = (nc_st_reg == csp_pkg::CSP_NC_IDLE)
		| (nc_st_reg == csp_pkg::CSP_NC_LOCK)
		| (nc_st_reg == csp_pkg::CSP_NC_DELAY && nc_trip_ev)
		| (nc_st_reg == csp_pkg::CSP_NC_RECL && nc_close_req && close_go);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			nc_tmr_reg <= '0;
		end else if (nc_st_reg == csp_pkg::CSP_NC_IDLE) begin
			nc_tmr_reg <= nc_dly_reg;
		end else if (nc_clr_tmr && nc_st_reg == csp_pkg::CSP_NC_DELAY) begin
			nc_tmr_reg <= nc_rcl_reg;
		end else if (nc_clr_tmr && nc_st_reg == csp_pkg::CSP_NC_RECL) begin
			nc_tmr_reg <= {8'h00, csp_pkg::NC_VERIFY_S};
		end else if (sec_tick && nc_tmr_reg != '0) begin
			nc_tmr_reg <= nc_tmr_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			lock_lamp_o <= 1'b0;
		end else begin
			lock_lamp_o <= lock_blk | nc_lock_ev;
		end
	end

	// ****************************************
	// power-up trip
	// ****************************************
	logic pu_pend_reg;
	logic [4:0] pu_age_reg;
	logic [csp_pkg::DW-1:0] pu_hold_reg;
	logic pu_tripped_reg;
	logic pu_trip_ev;

	// issued at once when allowed; given up at the 30 second mark
	assign pu_trip_req = pu_pend_reg & pu_en;
	assign pu_trip_ev = pu_trip_req & trip_go;
	// seconds since the power-up trip, so a delay written after reset still applies
	assign pu_blk = pu_tripped_reg & (pu_hold_reg < pu_dly_reg);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pu_pend_reg <= 1'b1;
			pu_age_reg <= 5'h00;
		end else if (pu_trip_ev) begin
			pu_pend_reg <= 1'b0;
		end else if (sec_tick && pu_pend_reg) begin
			pu_age_reg <= pu_age_reg + 5'h01;
			if (pu_age_reg == csp_pkg::PU_TRIP_LIMIT_S - 5'h01) begin
				pu_pend_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pu_hold_reg <= '0;
			pu_tripped_reg <= 1'b0;
		end else if (pu_trip_ev) begin
			pu_hold_reg <= '0;
			pu_tripped_reg <= 1'b1;
		end else if (sec_tick && pu_hold_reg != '1) begin
			pu_hold_reg <= pu_hold_reg + 1'b1;
		end
	end

	// ****************************************
	// auxiliary high voltage trip
	// ****************************************
	logic [csp_pkg::DW-1:0] aux_tmr_reg;
	logic aux_fired_reg;
	logic aux_over;

	// evaluated apart from every voltage control mode
	assign aux_over = aux_en & (line_volt_i > aux_lim_reg);
	assign aux_trip_req = aux_over & ~aux_fired_reg
		& (aux_tmr_reg >= aux_dly_reg);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			aux_tmr_reg <= '0;
			aux_fired_reg <= 1'b0;
		end else if (!aux_over) begin
			aux_tmr_reg <= '0;
			aux_fired_reg <= 1'b0;
		end else begin
			if (aux_trip_req && trip_go) begin
				aux_fired_reg <= 1'b1;
			end
			if (sec_tick && aux_tmr_reg != '1) begin
				aux_tmr_reg <= aux_tmr_reg + 1'b1;
			end
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	logic [csp_pkg::NEV-1:0] irq_stat_reg;
	logic [csp_pkg::NEV-1:0] ev_vec;
	logic [csp_pkg::NEV-1:0] irq_stat_next;
	logic stat_rd;

	assign ev_vec = {close_refused, aux_trip_req & trip_go, pu_trip_ev,
		nc_lock_ev, nc_trip_ev, hunt_ev};
	assign stat_rd = reg_rd_i & (reg_addr_i == csp_pkg::OFS_IRQ_STAT);
	// a new event in the read cycle survives the clear
	assign irq_stat_next = (stat_rd ? '0 : irq_stat_reg) | ev_vec;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_stat_reg <= '0;
			irq_o <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq_o <= |(irq_stat_next & irq_mask_reg);
		end
	end

	// ****************************************
	// read path
	// ****************************************
	logic [csp_pkg::DW-1:0] status_word;
	logic [csp_pkg::DW-1:0] rd_mux;

	assign status_word = {8'h00, nc_st_reg, pu_blk, dl_blk, ah_blk, uv_blk, lock_blk};

	always_comb begin
		rd_mux = '0;
		case (reg_addr_i)
			csp_pkg::OFS_CTRL: rd_mux = ctrl_reg;
			csp_pkg::OFS_AH_MIN: rd_mux = ah_min_reg;
			csp_pkg::OFS_AH_DLY: rd_mux = ah_dly_reg;
			csp_pkg::OFS_UV_LIM: rd_mux = uv_lim_reg;
			csp_pkg::OFS_DAY_MAX: rd_mux = day_max_reg;
			csp_pkg::OFS_NC_LIM: rd_mux = nc_lim_reg;
			csp_pkg::OFS_NC_DLY: rd_mux = nc_dly_reg;
			csp_pkg::OFS_NC_RCL: rd_mux = nc_rcl_reg;
			csp_pkg::OFS_AUX_LIM: rd_mux = aux_lim_reg;
			csp_pkg::OFS_AUX_DLY: rd_mux = aux_dly_reg;
			csp_pkg::OFS_PU_DLY: rd_mux = pu_dly_reg;
			csp_pkg::OFS_STATUS: rd_mux = status_word;
			csp_pkg::OFS_IRQ_STAT: rd_mux = {10'h000, irq_stat_reg};
			csp_pkg::OFS_IRQ_MASK: rd_mux = {10'h000, irq_mask_reg};
			csp_pkg::OFS_CLOSE_CNT: rd_mux = close_cnt_reg;
			csp_pkg::OFS_AH_ACC: rd_mux = ah_acc_reg;
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_mux : '0;
		end
	end
endmodule
`default_nettype wire

// ---- csp_protect_asserts.sv ----
// Purpose: port-level checks of the protection supervisor
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to csp_protect from the bench top file
`default_nettype none
module csp_protect_asserts #(
	parameter int unsigned SEC_CYCLES = csp_pkg::SEC_CYC_DEF
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [csp_pkg::AW-1:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [csp_pkg::DW-1:0] reg_rdata_o,
	// requests and pins
	input wire logic pri_close_i,
	input wire logic pri_trip_i,
	input wire logic reset_sw_i,
	// outputs
	input wire logic trip_o,
	input wire logic close_o,
	input wire logic lock_lamp_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	sequence sw_press_s;
		lock_lamp_o && !reset_sw_i ##1 reset_sw_i;
	endsequence
	sequence sw_quiet_s;
		!reset_sw_i [*5];
	endsequence
	sequence stat_read_s;
		reg_rd_i && reg_addr_i == csp_pkg::OFS_IRQ_STAT && !pri_close_i && !pri_trip_i
			##1 !trip_o && !$rose(lock_lamp_o);
	endsequence
	rst_out_a: assert property ($fell(sys_rst_i) |-> !trip_o && !close_o && !lock_lamp_o)
		else $error("outputs active after reset");
	rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
		else $error("read data outside answer cycle");
	no_both_a: assert property (!(trip_o && close_o))
		else $error("trip and close together");
	close_trip_a: assert property (close_o |-> !$past(pri_trip_i))
		else $error("close passed beside a trip request");
	lock_quiet_a: assert property (lock_lamp_o && $past(lock_lamp_o) |-> !close_o && !trip_o)
		else $error("relay moved in lockout");
	lock_hold_a: assert property (sw_quiet_s ##0 lock_lamp_o |=> lock_lamp_o)
		else $error("lockout left without switch");
	lock_exit_a: assert property (sw_press_s |-> ##[1:6] !lock_lamp_o)
		else $error("lockout kept after switch");
	irq_clear_a: assert property (stat_read_s |-> !irq_o)
		else $error("interrupt kept after status read");
endmodule
`default_nettype wire

// ---- csp_protect_test.sv ----
// Purpose: self-checking bench of the protection supervisor
// Assumes: one second shortened to 20 clocks
// Notes: scenario tasks run in order; hunting runs last
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module csp_protect_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SEC = 20;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic pc = 1'b0;
	logic pt = 1'b0;
	logic mid = 1'b0;
	logic sw = 1'b0;
	logic fail = 1'b0;
	logic [15:0] volt = 16'h0078;
	logic [15:0] neut = 16'h0000;
	logic [15:0] rdata;
	logic [15:0] d;
	logic trip, close, lamp, irq, bank, gc, gt, hit;
	int errors = 0;
	int samples_checked = 0;
	csp_protect #(.SEC_CYCLES(SEC)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .pri_close_i(pc), .pri_trip_i(pt), .midnight_i(mid),
		.line_volt_i(volt), .neut_curr_i(neut), .bank_closed_i(bank), .reset_sw_i(sw),
		.trip_o(trip), .close_o(close), .lock_lamp_o(lamp), .irq_o(irq));
	csp_bank_model u_bank (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .trip_i(trip),
		.close_i(close), .fail_i(fail), .bank_closed_o(bank));
	// ****************************************
	// bus and pin tasks
	// ****************************************
	task automatic wrr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic cmd(input logic c, input logic t);
		@(posedge clk_i);
		pc <= c;
		pt <= t;
		@(posedge clk_i);
		pc <= 1'b0;
		pt <= 1'b0;
		#1;
		gc = close;
		gt = trip;
	endtask
	// 0 trip, 1 close, 2 lamp on, 3 lamp off
	task automatic waitfor(input int w, input int lim);
		hit = 1'b0;
		repeat (lim) begin
			@(posedge clk_i);
			#1;
			if (w == 0 ? trip === 1'b1 : w == 1 ? close === 1'b1 : lamp === (w == 2)) begin
				hit = 1'b1;
				break;
			end
		end
	endtask
	task automatic tick_mid();
		@(posedge clk_i);
		mid <= 1'b1;
		@(posedge clk_i);
		mid <= 1'b0;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_power();
		waitfor(0, 30 * SEC + 4);
		`CHK("pu trip", 1'b1, hit)
		wrr(csp_pkg::OFS_PU_DLY, 16'h0002);
		rdr(csp_pkg::OFS_CTRL);
		`CHK("ctrl", 16'h0010, d)
		rdr(csp_pkg::OFS_NC_LIM);
		`CHK("nc lim", 16'hffff, d)
		cmd(1'b1, 1'b0);
		`CHK("pu hold", 1'b0, gc)
		repeat (2 * SEC) @(posedge clk_i);
		cmd(1'b1, 1'b1);
		`CHK("close vs trip", 1'b0, gc)
		`CHK("trip vs close", 1'b1, gt)
		cmd(1'b1, 1'b0);
		`CHK("pu free", 1'b1, gc)
	endtask
	task automatic t_uv();
		wrr(csp_pkg::OFS_UV_LIM, 16'h0064);
		wrr(csp_pkg::OFS_CTRL, 16'h0002);
		@(posedge clk_i) volt <= 16'h0064;
		cmd(1'b0, 1'b1);
		`CHK("uv trip", 1'b0, gt)
		cmd(1'b1, 1'b0);
		`CHK("uv close", 1'b0, gc)
		@(posedge clk_i) volt <= 16'h0065;
		cmd(1'b0, 1'b1);
		`CHK("uv free", 1'b1, gt)
	endtask
	task automatic t_daily();
		rdr(csp_pkg::OFS_IRQ_STAT);
		wrr(csp_pkg::OFS_IRQ_MASK, 16'h0020);
		wrr(csp_pkg::OFS_DAY_MAX, 16'h0002);
		wrr(csp_pkg::OFS_CTRL, 16'h0004);
		tick_mid();
		repeat (2) begin
			cmd(1'b1, 1'b0);
			`CHK("day close", 1'b1, gc)
		end
		wrr(csp_pkg::OFS_CLOSE_CNT, 16'h0000);
		rdr(csp_pkg::OFS_CLOSE_CNT);
		`CHK("count", 16'h0002, d)
		`CHK("irq idle", 1'b0, irq)
		cmd(1'b1, 1'b0);
		`CHK("day limit", 1'b0, gc)
		@(posedge clk_i);
		#1;
		`CHK("irq set", 1'b1, irq)
		rdr(csp_pkg::OFS_IRQ_STAT);
		`CHK("refused", 1'b1, d[csp_pkg::EV_REFUSED])
		`CHK("irq clear", 1'b0, irq)
		tick_mid();
		cmd(1'b1, 1'b0);
		`CHK("new day", 1'b1, gc)
	endtask
	task automatic t_aux();
		wrr(csp_pkg::OFS_AUX_LIM, 16'h00c8); // above any override level
		wrr(csp_pkg::OFS_AUX_DLY, 16'h0002);
		wrr(csp_pkg::OFS_CTRL, 16'h0020);
		@(posedge clk_i) volt <= 16'h012c;
		waitfor(0, 4 * SEC);
		`CHK("aux trip", 1'b1, hit)
		@(posedge clk_i) volt <= 16'h0078;
	endtask
	task automatic t_neut();
		wrr(csp_pkg::OFS_NC_LIM, 16'h000a);
		wrr(csp_pkg::OFS_NC_DLY, 16'h0002);
		wrr(csp_pkg::OFS_NC_RCL, 16'h0002);
		wrr(csp_pkg::OFS_CTRL, 16'h0008);
		@(posedge clk_i);
		neut <= 16'h0014;
		fail <= 1'b1;
		waitfor(0, SEC);
		`CHK("nc early", 1'b0, hit)
		waitfor(0, 3 * SEC);
		`CHK("nc trip", 1'b1, hit)
		@(posedge clk_i) neut <= 16'h0000;
		waitfor(1, 4 * SEC);
		`CHK("reclose", 1'b1, hit)
		waitfor(2, 12 * SEC);
		`CHK("lockout", 1'b1, hit)
		cmd(1'b1, 1'b1);
		`CHK("lock close", 1'b0, gc)
		`CHK("lock trip", 1'b0, gt)
		`CHK("lamp", 1'b1, lamp)
		@(posedge clk_i) sw <= 1'b1;
		waitfor(3, 8);
		`CHK("unlock", 1'b1, hit)
		@(posedge clk_i);
		sw <= 1'b0;
		fail <= 1'b0;
		neut <= 16'h0014;
		waitfor(0, 4 * SEC);
		`CHK("nc trip two", 1'b1, hit)
		@(posedge clk_i) neut <= 16'h0000;
		waitfor(1, 4 * SEC);
		`CHK("reclose two", 1'b1, hit)
		waitfor(2, 12 * SEC);
		`CHK("kept closed", 1'b0, hit)
	endtask
	task automatic t_hunt();
		wrr(csp_pkg::OFS_AH_MIN, 16'h0002);
		wrr(csp_pkg::OFS_AH_DLY, 16'h0002);
		wrr(csp_pkg::OFS_CTRL, 16'h0001);
		cmd(1'b1, 1'b0);
		cmd(1'b0, 1'b1);
		rdr(csp_pkg::OFS_AH_ACC);
		`CHK("acc one", 16'h0002, d)
		cmd(1'b1, 1'b0);
		`CHK("hunt block", 1'b0, gc)
		repeat (122 * SEC) @(posedge clk_i);
		cmd(1'b1, 1'b0);
		`CHK("hunt free", 1'b1, gc)
		cmd(1'b0, 1'b1);
		rdr(csp_pkg::OFS_AH_ACC);
		`CHK("acc two", 16'h0004, d)
		repeat (7) tick_mid();
		rdr(csp_pkg::OFS_AH_ACC);
		`CHK("acc week", 16'h0000, d)
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	// whole run is near 3100 clocks; allow far more
	initial begin
		#1500000;
		errors++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_power();
		t_uv();
		t_daily();
		t_aux();
		t_neut();
		t_hunt();
		print_verdict();
	end
endmodule
bind csp_protect csp_protect_asserts #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .pri_close_i(pri_close_i), .pri_trip_i(pri_trip_i),
	.reset_sw_i(reset_sw_i), .trip_o(trip_o), .close_o(close_o),
	.lock_lamp_o(lock_lamp_o), .irq_o(irq_o));
`undef CHK
`default_nettype wire
